// File: tb_top.sv
/*
 * tb_top: self-checking bench for tfc_trace_ctrl, with a bench model.
 * Assumes tfc_pkg and the design modules are compiled before this file.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // =====================================================================
    // design ports
    logic                        clk;
    logic                        rst;
    logic                        psel;
    logic                        penable;
    logic                        pwrite;
    logic [7:0]                  paddr;
    logic [31:0]                 pwdata;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    tfc_pkg::tfc_core_evt_type   core_evt;
    tfc_pkg::tfc_core_evt_type   ev;
    logic [31:0]                 table_word12;
    logic                        trace_fault_q;
    logic                        nontrace_call_q;
    logic                        priv_refused_q;
    logic                        sup_mode;
    logic                        use_sup_stack;
    logic [31:0]                 sup_stack_ptr;
    logic                        irq;
    // model state, kept from the rules alone
    logic                        m_te;
    logic                        m_sup;
    logic                        m_pend;
    logic [6:0]                  m_tmode;
    logic [6:0]                  m_evt;
    logic [2:0]                  m_stat;
    logic [2:0]                  m_mask;
    logic [31:0]                 m_ssp;
    logic [31:0]                 r;
    int                          err_count;
    int                          compares;

    tfc_trace_ctrl uut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_evt(core_evt),
        .table_word12(table_word12), .trace_fault_q(trace_fault_q),
        .nontrace_call_q(nontrace_call_q), .priv_refused_q(priv_refused_q),
        .sup_mode(sup_mode), .use_sup_stack(use_sup_stack),
        .sup_stack_ptr(sup_stack_ptr), .irq(irq)
    );

    // 25 MHz core clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // =====================================================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic tally_and_finish;
        if (err_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one apb transfer; waits for pready under a bound, no fixed latency
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            err_count++;
            tally_and_finish();
        end
    endtask : apb

    // write, then mirror the register effect in the model
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        case (a)
            tfc_pkg::OFF_PCR:  m_te = d[0];
            tfc_pkg::OFF_TCR: begin
                m_tmode = d[7:1];
                m_evt   = d[23:17];
            end
            tfc_pkg::OFF_STAT: m_stat = m_stat & ~d[2:0];
            tfc_pkg::OFF_MASK: m_mask = d[2:0];
            default: ;
        endcase
    endtask : wr

    task automatic rd(input string what, input logic [7:0] a,
                      input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(what, q, exp);
        chk("pslverr", {31'h0, e}, {31'h0, exp_err});
    endtask : rd

    // read back all mapped registers against the model
    task automatic rd_all;
        rd("pcr", tfc_pkg::OFF_PCR, {21'h0, m_pend, 8'h00, m_sup, m_te},
           1'b0);
        rd("tcr", tfc_pkg::OFF_TCR, {8'h00, m_evt, 9'h000, m_tmode, 1'b0},
           1'b0);
        rd("stat", tfc_pkg::OFF_STAT, {29'h0, m_stat}, 1'b0);
        rd("mask", tfc_pkg::OFF_MASK, {29'h0, m_mask}, 1'b0);
        rd("ssp", tfc_pkg::OFF_SSP, m_ssp, 1'b0);
    endtask : rd_all

    // one core event pulse; outputs are looked at in their one cycle
    task automatic step(input tfc_pkg::tfc_core_evt_type e,
                        input logic [31:0] w);
        logic hit;
        logic tf;
        logic pr;
        hit = m_te && ((e.sub_seen & m_tmode) != 7'h00);
        tf  = (hit && !e.nontrace_flt) || (e.flt_return && m_pend);
        pr  = e.priv_instr && !m_sup;
        @(posedge clk);
        core_evt     <= e;
        table_word12 <= w;
        @(posedge clk);
        core_evt <= '0;
        #1;
        if (m_te) m_evt = m_evt | (e.sub_seen & m_tmode);
        m_stat = m_stat | {pr, hit && e.nontrace_flt, tf};
        if (hit && e.nontrace_flt) m_pend = 1'b1;
        else if (e.flt_return) m_pend = 1'b0;
        // a call out of user mode outranks a return in the same cycle
        if (e.sup_call && !m_sup) begin
            m_te  = w[0];
            m_sup = 1'b1;
            m_ssp = w;
        end else if (e.user_return) begin
            m_sup = 1'b0;
        end
        chk("trace fault", {31'h0, trace_fault_q}, {31'h0, tf});
        chk("nontrace call", {31'h0, nontrace_call_q},
            {31'h0, e.nontrace_flt});
        chk("priv refused", {31'h0, priv_refused_q}, {31'h0, pr});
        chk("sup mode", {31'h0, sup_mode}, {31'h0, m_sup});
        chk("sup stack", {31'h0, use_sup_stack}, {31'h0, m_sup});
        chk("stack ptr", sup_stack_ptr, m_ssp);
        chk("irq", {31'h0, irq}, {31'h0, (m_stat & m_mask) != 3'h0});
    endtask : step

    // =====================================================================
    // main sequence
    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0000_0000; core_evt = '0;
        table_word12 = 32'h0000_0000; err_count = 0; compares = 0;
        m_te = 1'b0; m_sup = 1'b1; m_pend = 1'b0; m_tmode = 7'h00;
        m_evt = 7'h00; m_stat = 3'h0; m_mask = 3'h0; m_ssp = 32'h0;
        r = 32'd79149;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_all();
        // unmapped place is refused and reads zero
        wr(8'h14, 32'hFFFF_FFFF);
        rd("unmapped", 8'h14, 32'h0000_0000, 1'b1);
        wr(tfc_pkg::OFF_MASK, 32'h0000_0007);
        wr(tfc_pkg::OFF_TCR, 32'h0000_00FE);
        wr(tfc_pkg::OFF_PCR, 32'h0000_0001);
        // every subtype, one pulse each with an idle cycle between, then event bits read back
        for (int i = 0; i < 7; i++) begin
            ev = '0;
            ev.sub_seen = 7'h01 << i;
            step(ev, 32'h0000_0000);
        end
        rd_all();
        // random mode masks against random subtype pulses
        for (int i = 0; i < 8; i++) begin
            r = lfsr_next(r);
            wr(tfc_pkg::OFF_TCR, {24'h0, r[6:0], 1'b0});
            ev = '0;
            ev.sub_seen = r[13:7];
            step(ev, 32'h0000_0000);
        end
        // trace enable off gates the trace fault of every subtype
        wr(tfc_pkg::OFF_TCR, 32'h0000_00FE);
        wr(tfc_pkg::OFF_PCR, 32'h0000_0000);
        ev = '0;
        ev.sub_seen = 7'h7F;
        step(ev, 32'h0000_0000);
        wr(tfc_pkg::OFF_PCR, 32'h0000_0001);
        // coincidence defers the trace fault until handler return
        wr(tfc_pkg::OFF_STAT, 32'h0000_0007);
        ev.sub_seen = 7'h02;
        ev.nontrace_flt = 1'b1;
        step(ev, 32'h0000_0000);
        rd_all();
        ev = '0;
        ev.flt_return = 1'b1;
        step(ev, 32'h0000_0000);
        rd_all();
        // clearing and masking drop the interrupt
        wr(tfc_pkg::OFF_MASK, 32'h0000_0000);
        rd_all();
        wr(tfc_pkg::OFF_MASK, 32'h0000_0007);
        wr(tfc_pkg::OFF_STAT, 32'h0000_0007);
        rd_all();
        // user mode refusal and supervisor call reload, both te values
        for (int k = 0; k < 2; k++) begin
            r = lfsr_next(r);
            ev = '0;
            ev.user_return = 1'b1;
            step(ev, 32'h0000_0000);
            ev = '0;
            ev.priv_instr = 1'b1;
            step(ev, 32'h0000_0000);
            ev = '0;
            ev.sup_call = 1'b1;
            step(ev, {r[31:1], k[0]});
            ev = '0;
            ev.priv_instr = 1'b1;
            step(ev, 32'h0000_0000);
            rd_all();
        end
        // mid-run reset returns every register to its reset value
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        m_te = 1'b0; m_sup = 1'b1; m_pend = 1'b0; m_tmode = 7'h00;
        m_evt = 7'h00; m_stat = 3'h0; m_mask = 3'h0; m_ssp = 32'h0;
        rd_all();
        chk("irq after reset", {31'h0, irq}, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire

// File: tfc_event_detect.sv
/*
 * Trace event qualifier: one lane per trace subtype.
 * Assumes subtype pulses and mode bits are synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module tfc_event_detect #(
    parameter int NSUB = tfc_pkg::NUM_SUB
) (
    // subtype pulses from the core
    input  wire logic [NSUB-1:0] sub_seen,
    // tracing controls
    input  wire logic [NSUB-1:0] mode_en,
    input  wire logic            trace_en,
    // qualified events
    output logic      [NSUB-1:0] hit,
    output logic                 any_hit
);

    // =================================================================
    // per-lane qualification
    genvar g;
    generate
        for (g = 0; g < NSUB; g++) begin : g_lane
            assign hit[g] = sub_seen[g] & mode_en[g] & trace_en;
        end
    endgenerate

    assign any_hit = |hit;

endmodule : tfc_event_detect

`default_nettype wire

// File: tfc_pkg.sv
/*
 * Shared constants and carrier types for the trace fault control block.
 * Assumes one core clock and an APB master with 32-bit data.
 */
`default_nettype none

package tfc_pkg;

    // =================================================================
    // sizes
    localparam int NUM_SUB = 7;  // instr, branch, call, ret, preret, sup, bkpt
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int ST_W    = 3;

    // =================================================================
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_PCR  = 8'h00;  // process control
    localparam logic [ADDR_W-1:0] OFF_TCR  = 8'h04;  // trace control
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h08;  // sticky status, w1c
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h0C;  // interrupt mask
    localparam logic [ADDR_W-1:0] OFF_SSP  = 8'h10;  // supervisor stack ptr

    // =================================================================
    // field positions
    localparam int PCR_TE_BIT   = 0;   // trace enable
    localparam int PCR_MODE_BIT = 1;   // 1 = supervisor mode
    localparam int PCR_PEND_BIT = 10;  // trace fault pending
    localparam int TCR_MODE_LSB = 1;   // mode bits [7:1]
    localparam int TCR_EVT_LSB  = 17;  // event bits [23:17]
    localparam int TBL_TE_BIT   = 0;   // trace control bit of table word
    localparam int ST_TRACE     = 0;   // trace fault delivered
    localparam int ST_DEFER     = 1;   // trace fault deferred
    localparam int ST_PRIV      = 2;   // privileged instruction refused

    // =================================================================
    // reset values
    localparam logic              TE_RST   = 1'b0;
    localparam logic              MODE_RST = 1'b1;  // core starts supervisor
    localparam logic [NUM_SUB-1:0] SUB_RST = 7'h00;
    localparam logic [ST_W-1:0]   ST_RST   = 3'h0;
    localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;

    // =================================================================
    // events reported by the core pipeline, all one-cycle pulses
    typedef struct packed {
        logic [NUM_SUB-1:0] sub_seen;      // trace subtype executed
        logic               nontrace_flt;  // other fault detected
        logic               flt_return;    // fault handler returned
        logic               sup_call;      // supervisor-type system call
        logic               user_return;   // return to user mode
        logic               priv_instr;    // supervisor-only instruction
    } tfc_core_evt_type;

endpackage : tfc_pkg

`default_nettype wire

// File: tfc_trace_ctrl.sv
/*
 * Trace fault control with APB register access and one interrupt.
 * Assumes core event pulses synchronous to clk and a system table word
 * (byte 12 of the procedure table) presented by the core at each call.
 */
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module tfc_trace_ctrl #(
    parameter int NSUB = tfc_pkg::NUM_SUB
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [tfc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [tfc_pkg::DATA_W-1:0] pwdata,
    output logic      [tfc_pkg::DATA_W-1:0] prdata,
    output logic                           pready,
    output logic                           pslverr,
    // core side
    input  wire tfc_pkg::tfc_core_evt_type core_evt,
    input  wire logic [tfc_pkg::DATA_W-1:0] table_word12,
    output logic                           trace_fault_q,
    output logic                           nontrace_call_q,
    output logic                           priv_refused_q,
    output logic                           sup_mode,
    output logic                           use_sup_stack,
    output logic      [tfc_pkg::DATA_W-1:0] sup_stack_ptr,
    // interrupt
    output logic                           irq
);

    // =================================================================
    // address decode, shared by read and write paths
    function automatic logic is_reg(input logic [tfc_pkg::ADDR_W-1:0] a,
                                    input logic [tfc_pkg::ADDR_W-1:0] o);
        is_reg = (a == o);
    endfunction : is_reg

    function automatic logic mapped(input logic [tfc_pkg::ADDR_W-1:0] a);
        mapped = is_reg(a, tfc_pkg::OFF_PCR)  | is_reg(a, tfc_pkg::OFF_TCR)
               | is_reg(a, tfc_pkg::OFF_STAT) | is_reg(a, tfc_pkg::OFF_MASK)
               | is_reg(a, tfc_pkg::OFF_SSP);
    endfunction : mapped

    // =================================================================
    // state
    logic                      te_q;
    logic                      mode_q;
    logic                      pend_q;
    logic [NSUB-1:0]           tc_mode_q;
    logic [NSUB-1:0]           tc_evt_q;
    logic [tfc_pkg::ST_W-1:0]  stat_q;
    logic [tfc_pkg::ST_W-1:0]  mask_q;
    logic [tfc_pkg::DATA_W-1:0] ssp_q;
    logic [NSUB-1:0]           hit;
    logic                      any_hit;
    logic                      wr_acc;
    logic                      rd_setup;
    logic                      enter_sup;
    logic                      coincide;
    logic                      trace_d;
    logic [tfc_pkg::ST_W-1:0]  stat_set;
    logic [tfc_pkg::DATA_W-1:0] rd_word;

    // =================================================================
    // event qualification
    tfc_event_detect #(
        .NSUB (NSUB)
    ) u_detect (
        .sub_seen (core_evt.sub_seen),
        .mode_en  (tc_mode_q),
        .trace_en (te_q),
        .hit      (hit),
        .any_hit  (any_hit)
    );

    // =================================================================
    // apb handshake: zero wait states, data prepared in the setup cycle
    assign wr_acc   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready   = psel & penable;
    assign pslverr  = psel & penable & ~mapped(paddr);

    // fault sequencing terms
    assign enter_sup = core_evt.sup_call & ~mode_q;
    assign coincide  = any_hit & core_evt.nontrace_flt;
    // deferred fault fires on handler return
    assign trace_d   = (any_hit & ~core_evt.nontrace_flt)
                     | (core_evt.flt_return & pend_q);
    assign stat_set  = {core_evt.priv_instr & ~mode_q, coincide, trace_d};

    // =================================================================
    // trace enable: hardware load wins over a software write
    always_ff @(posedge clk) begin
        if (rst) begin
            te_q <= tfc_pkg::TE_RST;
        end else if (enter_sup) begin
            te_q <= table_word12[tfc_pkg::TBL_TE_BIT];
        end else if (wr_acc && is_reg(paddr, tfc_pkg::OFF_PCR)) begin
            te_q <= pwdata[tfc_pkg::PCR_TE_BIT];
        end
    end

    // =================================================================
    // execution mode follows the core's calls and returns only
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= tfc_pkg::MODE_RST;
        end else if (enter_sup) begin
            mode_q <= 1'b1;
        end else if (core_evt.user_return) begin
            mode_q <= 1'b0;
        end
    end

    // =================================================================
    // supervisor stack pointer captured with the call
    always_ff @(posedge clk) begin
        if (rst) begin
            ssp_q <= tfc_pkg::WORD_RST;
        end else if (enter_sup) begin
            ssp_q <= table_word12;
        end
    end

    assign sup_mode      = mode_q;
    assign use_sup_stack = mode_q;
    assign sup_stack_ptr = ssp_q;

    // =================================================================
    // pending flag: a new coincidence outranks the return that clears it
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_q <= 1'b0;
        end else if (coincide) begin
            pend_q <= 1'b1;
        end else if (core_evt.flt_return) begin
            pend_q <= 1'b0;
        end
    end

    // =================================================================
    // fault outputs, one-cycle pulses
    always_ff @(posedge clk) begin
        if (rst) begin
            trace_fault_q   <= 1'b0;
            nontrace_call_q <= 1'b0;
            priv_refused_q  <= 1'b0;
        end else begin
            trace_fault_q   <= trace_d;
            nontrace_call_q <= core_evt.nontrace_flt;
            priv_refused_q  <= core_evt.priv_instr & ~mode_q;
        end
    end

    // =================================================================
    // trace control: mode bits written by software, event bits sticky
    always_ff @(posedge clk) begin
        if (rst) begin
            tc_mode_q <= tfc_pkg::SUB_RST;
        end else if (wr_acc && is_reg(paddr, tfc_pkg::OFF_TCR)) begin
            tc_mode_q <= pwdata[tfc_pkg::TCR_MODE_LSB +: NSUB];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tc_evt_q <= tfc_pkg::SUB_RST;
        end else if (wr_acc && is_reg(paddr, tfc_pkg::OFF_TCR)) begin
            tc_evt_q <= pwdata[tfc_pkg::TCR_EVT_LSB +: NSUB] | hit;
        end else begin
            tc_evt_q <= tc_evt_q | hit;
        end
    end

    // =================================================================
    // interrupt status, write one to clear, set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            stat_q <= tfc_pkg::ST_RST;
        end else if (wr_acc && is_reg(paddr, tfc_pkg::OFF_STAT)) begin
            stat_q <= (stat_q & ~pwdata[tfc_pkg::ST_W-1:0]) | stat_set;
        end else begin
            stat_q <= stat_q | stat_set;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask_q <= tfc_pkg::ST_RST;
        end else if (wr_acc && is_reg(paddr, tfc_pkg::OFF_MASK)) begin
            mask_q <= pwdata[tfc_pkg::ST_W-1:0];
        end
    end

    assign irq = |(stat_q & mask_q);

    // =================================================================
    // read mux; unused bits read zero
    always_comb begin
        rd_word = tfc_pkg::WORD_RST;
        if (is_reg(paddr, tfc_pkg::OFF_PCR)) begin
            rd_word[tfc_pkg::PCR_TE_BIT]   = te_q;
            rd_word[tfc_pkg::PCR_MODE_BIT] = mode_q;
            rd_word[tfc_pkg::PCR_PEND_BIT] = pend_q;
        end else if (is_reg(paddr, tfc_pkg::OFF_TCR)) begin
            rd_word[tfc_pkg::TCR_MODE_LSB +: NSUB] = tc_mode_q;
            rd_word[tfc_pkg::TCR_EVT_LSB +: NSUB]  = tc_evt_q;
        end else if (is_reg(paddr, tfc_pkg::OFF_STAT)) begin
            rd_word[tfc_pkg::ST_W-1:0] = stat_q;
        end else if (is_reg(paddr, tfc_pkg::OFF_MASK)) begin
            rd_word[tfc_pkg::ST_W-1:0] = mask_q;
        end else if (is_reg(paddr, tfc_pkg::OFF_SSP)) begin
            rd_word = ssp_q;
        end
    end

    // read data is registered during the setup cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= tfc_pkg::WORD_RST;
        end else if (rd_setup) begin
            prdata <= rd_word;
        end
    end

    // =================================================================
    // checks
    // no new trace fault when disabled
    property p_te_gate;
        @(posedge clk) disable iff (rst)
        (!te_q && !pend_q) |=> !trace_fault_q;
    endproperty
    a_te_gate: assert property (p_te_gate)
        else $error("trace fault raised while tracing disabled");

    property p_sup_load;
        @(posedge clk) disable iff (rst)
        (core_evt.sup_call && !mode_q) |=>
            (te_q == $past(table_word12[tfc_pkg::TBL_TE_BIT])) && mode_q;
    endproperty
    a_sup_load: assert property (p_sup_load)
        else $error("trace enable not loaded on supervisor call");

    property p_tc_mode;
        @(posedge clk) disable iff (rst)
        (wr_acc && is_reg(paddr, tfc_pkg::OFF_TCR)) |=>
            tc_mode_q == $past(pwdata[tfc_pkg::TCR_MODE_LSB +: NSUB]);
    endproperty
    a_tc_mode: assert property (p_tc_mode)
        else $error("trace mode bits not written");

    property p_raise;
        @(posedge clk) disable iff (rst)
        (te_q && (|(core_evt.sub_seen & tc_mode_q))
         && !core_evt.nontrace_flt) |=> trace_fault_q;
    endproperty
    a_raise: assert property (p_raise)
        else $error("enabled trace event raised no fault");

    property p_defer;
        @(posedge clk) disable iff (rst)
        (any_hit && core_evt.nontrace_flt) |=>
            pend_q && nontrace_call_q
            && (trace_fault_q == $past(core_evt.flt_return && pend_q));
    endproperty
    a_defer: assert property (p_defer)
        else $error("coincident trace fault not deferred");

    property p_resume;
        @(posedge clk) disable iff (rst)
        (core_evt.flt_return && pend_q && !coincide) |=>
            trace_fault_q && !pend_q;
    endproperty
    a_resume: assert property (p_resume)
        else $error("pending trace fault lost on return");

    property p_ssp;
        @(posedge clk) disable iff (rst)
        (core_evt.sup_call && !mode_q) |=>
            sup_stack_ptr == $past(table_word12) && use_sup_stack;
    endproperty
    a_ssp: assert property (p_ssp)
        else $error("supervisor stack pointer not taken");

    property p_priv;
        @(posedge clk) disable iff (rst)
        (core_evt.priv_instr && !mode_q) |=>
            priv_refused_q && stat_q[tfc_pkg::ST_PRIV];
    endproperty
    a_priv: assert property (p_priv)
        else $error("user mode privileged instruction not refused");

    property p_evt_bit;
        @(posedge clk) disable iff (rst)
        any_hit |=> (tc_evt_q & $past(hit)) == $past(hit);
    endproperty
    a_evt_bit: assert property (p_evt_bit)
        else $error("event bit missing at trace fault");

endmodule : tfc_trace_ctrl

`default_nettype wire
